// [src/afe_pkg.sv]
package afe_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint unsigned CORE_CLK_HZ = 200000000;
  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned SETTLE_TIME_NS = 25000;
  // A least time, so it rounds up to whole cycles.
  localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam longint unsigned OSC_NORMAL_HZ = 1024000;
  localparam longint unsigned OSC_TURBO_HZ = 2048000;
  localparam int unsigned ACC_W = 32;
  localparam logic [31:0] OSC_STEP_NORMAL = 32'((OSC_NORMAL_HZ << ACC_W) / CORE_CLK_HZ);
  localparam logic [31:0] OSC_STEP_TURBO = 32'((OSC_TURBO_HZ << ACC_W) / CORE_CLK_HZ);
  localparam logic [1:0] MOD_DIV_LAST = 2'h3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CONFIG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] MODCNT_OFS = 12'h008;
  localparam logic [11:0] CONFIG_RESET = 12'h000;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_SUPPLY = 2'h2;
  localparam logic [1:0] INSEL_AVSS_PREFIX = 2'h2;
  localparam logic [2:0] CAP_ONLY_MAX_EXP = 3'h2;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_READY = 2'b10
  } settle_e;

  // Bit 0 upward: gain_sel[2:0], amp_bypass, input_select[7:4],
  // ref_select[9:8], turbo[10], power_down[11].
  typedef struct packed {
    logic power_down;
    logic turbo;
    logic [1:0] ref_select;
    logic [3:0] input_select;
    logic amp_bypass;
    logic [2:0] gain_sel;
  } cfg_s;

  typedef struct packed {
    logic ref_ready;
    logic turbo;
    logic ref_buf_en;
    logic [1:0] ref_src;
    logic cap_buf_en;
    logic amp_en;
    logic [1:0] cap_exp;
    logic [2:0] amp_exp;
    logic [2:0] eff_gain;
  } status_s;

  typedef struct packed {
    logic [31:0] acc;
    logic tick;
  } accum_s;

  typedef struct packed {
    settle_e st;
    logic [15:0] cnt;
  } settle_s;

endpackage

// [src/phase_accum.sv]
`timescale 1ns/1ps
module phase_accum #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [31:0] step,
  // Tick
  output logic tick
);

  afe_pkg::accum_s q;
  afe_pkg::accum_s d;
  logic [32:0] sum;

  // Fractional division keeps the long-run rate within a part per million; single ticks jitter by one cycle.
  always_comb begin
    sum = {1'b0, q.acc} + {1'b0, step};
    d = q;
    d.tick = 1'b0;
    if (en) begin
      d.acc = sum[31:0];
      d.tick = sum[32];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

// [src/settle_timer.sv]
`timescale 1ns/1ps
module settle_timer #(
  parameter int unsigned CYCLES = 5000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  // Status
  output logic ready
);

  afe_pkg::settle_s q;
  afe_pkg::settle_s d;

  // Reset lands in the settle state, so power-up is covered too.
  always_comb begin
    d = q;
    case (q.st)
      afe_pkg::ST_SETTLE: begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == 16'(CYCLES - 1)) begin
          d.st = afe_pkg::ST_READY;
        end
      end
      afe_pkg::ST_READY: begin
        d.cnt = '0;
      end
      default: begin
        d.st = afe_pkg::ST_SETTLE;
        d.cnt = '0;
      end
    endcase
    if (start) begin
      d.st = afe_pkg::ST_SETTLE;
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: afe_pkg::ST_SETTLE, cnt: 16'h0000};
    end else begin
      q <= d;
    end
  end

  assign ready = (q.st == afe_pkg::ST_READY);

  property p_settle_bound;
    @(posedge clk) disable iff (rst)
    q.st == afe_pkg::ST_SETTLE |-> q.cnt < 16'(CYCLES);
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settle count overran"); // R11

endmodule

// [src/adc_gain_ref_clock_control.sv]
`timescale 1ns/1ps
// How it works
// R1 - Eight overall gains 1 to 128, powers of two, from a 3-bit field.
// R2 - Gain code n means overall gain two to the n; code 0 is unity.
// R3 - Gains 1,2,4 use capacitor stage only; higher use capacitor 4 plus amplifier.
// R4 - Bypass bit with gain 1, 2 or 4 disables amplifier, feeds capacitor stage.
// R5 - Input select 1000 to 1011 forces bypass, whatever the bypass bit says.
// R6 - Under forced bypass a gain above 4 is clamped to 4.
// R7 - Amplifier off means capacitor stage gives 1, 2, 4 with input buffer on.
// R8 - Two-bit reference select; internal reference after reset.
// R9 - Choices are internal reference, external pin pair, analog supply.
// R10 - Codes: 00 internal, 01 external pins, 10 and 11 analog supply.
// R11 - Results untrusted for 25 us after power-up, wake, or external-to-internal.
// R12 - External reference enables reference buffers; other sources leave them off.
// R13 - Modulator clock is the oscillator clock divided by four.
// R14 - Normal mode 1.024 MHz oscillator; turbo mode 2.048 MHz.
// R15 - Four-bit input select picks inputs, some tying negative input to supply.
module adc_gain_ref_clock_control #(
  parameter int unsigned SETTLE_CYCLES = afe_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Gain path
  output logic AMP_ENABLE,
  output logic [2:0] AMP_GAIN_EXP,
  output logic [1:0] CAP_GAIN_EXP,
  output logic CAP_BUFFER_EN,
  output logic [3:0] INPUT_SELECT,
  // Reference
  output logic [1:0] REF_SOURCE,
  output logic REF_BUFFER_EN,
  output logic REF_READY,
  // Clocking
  output logic OSC_TICK,
  output logic MOD_TICK
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    afe_pkg::cfg_s cfg;
    afe_pkg::status_s stat;
    logic [3:0] insel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] mod_cnt;
    logic mod_tick;
    logic osc_tick;
    logic [15:0] mod_count;
  } top_s;

  top_s q;
  top_s d;
  logic osc_pulse;
  logic timer_ready;
  logic settle_start;
  logic forced;
  logic take;
  logic [2:0] eff;
  logic [31:0] step;
  logic [11:0] wcfg;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Turbo doubles the oscillator rate and with it the modulator rate.
  assign step = q.cfg.turbo ? afe_pkg::OSC_STEP_TURBO : afe_pkg::OSC_STEP_NORMAL; // R14

  phase_accum #(
    .WIDTH(afe_pkg::ACC_W)
  ) u_osc (
    .clk(CORE_CLK),
    .rst(RST),
    .en(!q.cfg.power_down),
    .step(step),
    .tick(osc_pulse)
  );

  settle_timer #(
    .CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk(CORE_CLK),
    .rst(RST),
    .start(settle_start),
    .ready(timer_ready)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign take = PSEL && PENABLE && q.pready;
  assign forced = q.cfg.input_select[3:2] == afe_pkg::INSEL_AVSS_PREFIX; // R5 R15
  assign wcfg = {PSTRB[1] ? PWDATA[11:8] : q.cfg[11:8], PSTRB[0] ? PWDATA[7:0] : q.cfg[7:0]};

  always_comb begin
    d = q;
    settle_start = 1'b0;

    // One wait state: PREADY is a flop raised in the first access cycle.
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (PSEL && PENABLE && !q.pready) begin
      d.pready = 1'b1;
      d.prdata = '0;
      case (PADDR)
        afe_pkg::CONFIG_OFS: begin
          d.prdata = {20'h00000, q.cfg};
        end
        afe_pkg::STATUS_OFS: begin
          d.prdata = {17'h0, q.stat};
        end
        afe_pkg::MODCNT_OFS: begin
          d.prdata = {16'h0000, q.mod_count};
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
      if (PWRITE) begin
        d.prdata = '0;
      end
    end
    if (take && PWRITE && PADDR == afe_pkg::CONFIG_OFS) begin
      d.cfg = afe_pkg::cfg_s'(wcfg);
    end
    // Leaving an external reference for the internal one restarts settling.
    if (q.cfg.ref_select == afe_pkg::REF_EXTERNAL
        && d.cfg.ref_select == afe_pkg::REF_INTERNAL) begin
      settle_start = 1'b1; // R11
    end
    if (q.cfg.power_down && !d.cfg.power_down) begin
      settle_start = 1'b1; // R11
    end

    // Gain decode from the stored configuration.
    eff = q.cfg.gain_sel; // R1 R2
    if (forced && q.cfg.gain_sel > afe_pkg::CAP_ONLY_MAX_EXP) begin
      eff = afe_pkg::CAP_ONLY_MAX_EXP; // R6
    end
    d.stat.eff_gain = eff;
    if (forced || (q.cfg.amp_bypass && q.cfg.gain_sel <= afe_pkg::CAP_ONLY_MAX_EXP)) begin
      d.stat.amp_en = 1'b0; // R4 R5
      d.stat.amp_exp = 3'h0;
      d.stat.cap_exp = eff[1:0];
      d.stat.cap_buf_en = 1'b1; // R7
    end else if (eff <= afe_pkg::CAP_ONLY_MAX_EXP) begin
      d.stat.amp_en = 1'b1;
      d.stat.amp_exp = 3'h0; // R3
      d.stat.cap_exp = eff[1:0];
      d.stat.cap_buf_en = 1'b0;
    end else begin
      d.stat.amp_en = 1'b1;
      d.stat.amp_exp = eff - afe_pkg::CAP_ONLY_MAX_EXP; // R3
      d.stat.cap_exp = afe_pkg::CAP_ONLY_MAX_EXP[1:0];
      d.stat.cap_buf_en = 1'b0;
    end
    d.insel = q.cfg.input_select; // R15

    // Reference decode; codes 10 and 11 both pick the analog supply.
    case (q.cfg.ref_select)
      afe_pkg::REF_INTERNAL: d.stat.ref_src = afe_pkg::REF_INTERNAL; // R9 R10
      afe_pkg::REF_EXTERNAL: d.stat.ref_src = afe_pkg::REF_EXTERNAL; // R10
      default: d.stat.ref_src = afe_pkg::REF_SUPPLY; // R10
    endcase
    d.stat.ref_buf_en = q.cfg.ref_select == afe_pkg::REF_EXTERNAL; // R12
    d.stat.ref_ready = timer_ready && !q.cfg.power_down; // R11
    d.stat.turbo = q.cfg.turbo; // R14

    // Modulator enable: every fourth oscillator tick.
    d.osc_tick = osc_pulse;
    d.mod_tick = 1'b0;
    if (osc_pulse) begin
      d.mod_cnt = q.mod_cnt + 2'h1; // R13
      if (q.mod_cnt == afe_pkg::MOD_DIV_LAST) begin
        d.mod_tick = 1'b1; // R13
        d.mod_count = q.mod_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q <= '0;
      q.cfg <= afe_pkg::cfg_s'(afe_pkg::CONFIG_RESET); // R8
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign AMP_ENABLE = q.stat.amp_en;
  assign AMP_GAIN_EXP = q.stat.amp_exp;
  assign CAP_GAIN_EXP = q.stat.cap_exp;
  assign CAP_BUFFER_EN = q.stat.cap_buf_en;
  assign INPUT_SELECT = q.insel;
  assign REF_SOURCE = q.stat.ref_src;
  assign REF_BUFFER_EN = q.stat.ref_buf_en;
  assign REF_READY = q.stat.ref_ready;
  assign OSC_TICK = q.osc_tick;
  assign MOD_TICK = q.mod_tick;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_total_gain;
    @(posedge CORE_CLK) disable iff (RST)
    !$past(RST) |-> 3'(AMP_GAIN_EXP + 3'(CAP_GAIN_EXP)) == $past(eff);
  endproperty
  a_total_gain: assert property (p_total_gain) else $error("overall gain wrong"); // R2

  property p_split;
    @(posedge CORE_CLK) disable iff (RST)
    (!forced && !q.cfg.amp_bypass && q.cfg.gain_sel > 3'h2)
    |=> AMP_ENABLE && CAP_GAIN_EXP == 2'h2 && AMP_GAIN_EXP == $past(q.cfg.gain_sel) - 3'h2;
  endproperty
  a_split: assert property (p_split) else $error("stage split wrong"); // R3

  property p_bypass;
    @(posedge CORE_CLK) disable iff (RST)
    (q.cfg.amp_bypass && q.cfg.gain_sel <= 3'h2)
    |=> !AMP_ENABLE && CAP_GAIN_EXP == $past(q.cfg.gain_sel[1:0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("optional bypass missed"); // R4

  property p_forced;
    @(posedge CORE_CLK) disable iff (RST)
    forced |=> !AMP_ENABLE && AMP_GAIN_EXP == 3'h0;
  endproperty
  a_forced: assert property (p_forced) else $error("forced bypass missed"); // R5

  property p_clamp;
    @(posedge CORE_CLK) disable iff (RST)
    (forced && q.cfg.gain_sel > 3'h2) |=> CAP_GAIN_EXP == 2'h2;
  endproperty
  a_clamp: assert property (p_clamp) else $error("gain not clamped"); // R6

  property p_cap_buffer;
    @(posedge CORE_CLK) disable iff (RST)
    !$past(RST) |-> AMP_ENABLE != CAP_BUFFER_EN;
  endproperty
  a_cap_buffer: assert property (p_cap_buffer) else $error("input buffer wrong"); // R7

  property p_ref_reset;
    @(posedge CORE_CLK)
    $past(RST) && !RST |-> REF_SOURCE == 2'h0 && !REF_READY;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reset ref wrong"); // R8

  property p_ref_buf;
    @(posedge CORE_CLK) disable iff (RST)
    q.cfg.ref_select == 2'h1 |=> REF_BUFFER_EN ##0 REF_SOURCE == 2'h1;
  endproperty
  a_ref_buf: assert property (p_ref_buf) else $error("ref buffer off"); // R12

  property p_ref_supply;
    @(posedge CORE_CLK) disable iff (RST)
    q.cfg.ref_select[1] |=> REF_SOURCE == 2'h2 && !REF_BUFFER_EN;
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("supply ref wrong"); // R10

  property p_ref_switch;
    @(posedge CORE_CLK) disable iff (RST)
    settle_start |=> ##1 !REF_READY [*8];
  endproperty
  a_ref_switch: assert property (p_ref_switch) else $error("ready too soon"); // R11

  // Both ticks launch from one oscillator pulse, so they share a cycle.
  property p_mod_div;
    @(posedge CORE_CLK) disable iff (RST)
    MOD_TICK |-> OSC_TICK && q.mod_cnt == 2'h0;
  endproperty
  a_mod_div: assert property (p_mod_div) else $error("modulator divide wrong"); // R13

  property p_pready;
    @(posedge CORE_CLK) disable iff (RST)
    PREADY |=> !PREADY;
  endproperty
  a_pready: assert property (p_pready) else $error("pready held");

  c_clamp: cover property (@(posedge CORE_CLK) disable iff (RST)
    forced && q.cfg.gain_sel == 3'h7);
  c_opt_bypass: cover property (@(posedge CORE_CLK) disable iff (RST)
    !AMP_ENABLE && !forced);
  c_turbo_mod: cover property (@(posedge CORE_CLK) disable iff (RST)
    q.cfg.turbo && MOD_TICK);
  c_ref_ready: cover property (@(posedge CORE_CLK) disable iff (RST)
    $rose(REF_READY));

endmodule

// [verification/test_adc_gain_ref_clock_control.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module test_adc_gain_ref_clock_control;
  // ********************
  // Bench signals
  // ********************
  localparam int unsigned SC = 20;
  logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0] PSTRB, INPUT_SELECT;
  logic AMP_ENABLE, CAP_BUFFER_EN, REF_BUFFER_EN, REF_READY, OSC_TICK, MOD_TICK;
  logic [2:0] AMP_GAIN_EXP;
  logic [1:0] CAP_GAIN_EXP, REF_SOURCE;
  int num_errors = 0;
  int checks = 0;

  adc_gain_ref_clock_control #(.SETTLE_CYCLES(SC)) adc_gain_ref_clock_control_i (
    .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .AMP_ENABLE(AMP_ENABLE), .AMP_GAIN_EXP(AMP_GAIN_EXP),
    .CAP_GAIN_EXP(CAP_GAIN_EXP), .CAP_BUFFER_EN(CAP_BUFFER_EN),
    .INPUT_SELECT(INPUT_SELECT), .REF_SOURCE(REF_SOURCE), .REF_BUFFER_EN(REF_BUFFER_EN),
    .REF_READY(REF_READY), .OSC_TICK(OSC_TICK), .MOD_TICK(MOD_TICK));

  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  // ********************
  // Tasks
  // ********************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The request is held until PREADY is seen high, then released at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    `CHK(PREADY, 1'b1)
    if (PREADY !== 1'b1) close_out();
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  // Outputs are decoded one cycle after CONFIG changes; two edges of slack.
  task automatic setcfg(input logic [11:0] c);
    apb(1'b1, afe_pkg::CONFIG_OFS, {20'h0, c}, 4'hf);
    repeat (2) @(posedge CORE_CLK);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (REF_READY !== 1'b1 && n < 500) begin
      @(posedge CORE_CLK);
      n++;
    end
    `CHK(n >= SC - 4 && n <= SC + 6, 1'b1)
    if (REF_READY !== 1'b1) close_out();
  endtask

  task automatic clk_test(input logic t, input longint hz);
    int osc, md, run, ex;
    logic [15:0] m0;
    osc = 0;
    md = 0;
    run = -1;
    ex = int'(20000 * hz / afe_pkg::CORE_CLK_HZ);
    setcfg({1'b0, t, 10'h0});
    rdr(afe_pkg::MODCNT_OFS);
    m0 = rd[15:0];
    repeat (20000) begin
      @(posedge CORE_CLK);
      if (MOD_TICK === 1'b1) begin
        `CHK(OSC_TICK, 1'b1)
        if (run >= 0) `CHK(run, 4)
        run = 0;
        md++;
      end
      if (OSC_TICK === 1'b1) begin
        osc++;
        if (run >= 0) run++;
      end
    end
    `CHK(osc >= ex - 1 && osc <= ex + 1, 1'b1)
    `CHK(md >= ex / 4 - 1 && md <= ex / 4 + 1, 1'b1)
    rdr(afe_pkg::MODCNT_OFS);
    m0 = rd[15:0] - m0;
    `CHK(m0 >= 16'(md) && m0 <= 16'(md + 1), 1'b1)
    $display("clock test done, turbo %0d", t);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    logic [2:0] eff;
    logic off;
    logic [31:0] s0;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    PSTRB = 4'h0;
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    `CHK(REF_READY, 1'b0)
    `CHK(REF_SOURCE, afe_pkg::REF_INTERNAL)
    wait_ready();
    $display("reset test done");

    rdr(afe_pkg::CONFIG_OFS);
    `CHK(rd, {20'h0, afe_pkg::CONFIG_RESET})
    rdr(12'h00c);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    rdr(afe_pkg::STATUS_OFS);
    s0 = rd;
    apb(1'b1, afe_pkg::STATUS_OFS, 32'hffffffff, 4'hf);
    rdr(afe_pkg::STATUS_OFS);
    `CHK(rd, s0)
    apb(1'b1, afe_pkg::CONFIG_OFS, 32'h00000fff, 4'h1);
    rdr(afe_pkg::CONFIG_OFS);
    `CHK(rd, 32'h000000ff)
    $display("register test done");

    for (int k = 0; k < 256; k++) begin
      off = (k[7:6] == 2'b10) || (k[3] && k[2:0] <= 3'h2);
      eff = (k[7:6] == 2'b10 && k[2:0] > 3'h2) ? 3'h2 : k[2:0];
      setcfg({4'h0, k[7:0]});
      `CHK(INPUT_SELECT, k[7:4])
      `CHK(AMP_ENABLE, !off)
      `CHK(CAP_BUFFER_EN, off)
      `CHK(AMP_GAIN_EXP, (eff > 3'h2) ? eff - 3'h2 : 3'h0)
      `CHK(CAP_GAIN_EXP, (eff > 3'h2) ? 2'h2 : eff[1:0])
      rdr(afe_pkg::STATUS_OFS);
      `CHK(rd[2:0], eff)
    end
    $display("gain test done");

    for (int r = 0; r < 4; r++) begin
      setcfg({2'h0, r[1:0], 8'h00});
      `CHK(REF_SOURCE, (r > 1) ? afe_pkg::REF_SUPPLY : r[1:0])
      `CHK(REF_BUFFER_EN, r == 1)
    end
    setcfg(12'h100);
    setcfg(12'h000);
    `CHK(REF_READY, 1'b0)
    wait_ready();
    setcfg(12'h800);
    `CHK(REF_READY, 1'b0)
    setcfg(12'h000);
    wait_ready();
    $display("reference test done");

    clk_test(1'b0, afe_pkg::OSC_NORMAL_HZ);
    clk_test(1'b1, afe_pkg::OSC_TURBO_HZ);
    close_out();
  end
endmodule
